/* File: verilog/hpp_decode.sv */
/*
 Host parallel port decode and handshake logic for a signal processor's external bus.
 Assumes proc_strobe and address come from the processor on sys_clk; host pins are asynchronous.
 The init line from the host is the asynchronous reset rst_b.
*/
// Operation
// - Host access is bus strobe combined with address lines 23 to 12.
// - Disconnect input floats the interrupt and ready outputs.
// - Five user selects plus ready, interrupt and transceiver enable are produced.
// - Led_mode_a input high lets user I/O and boot selects drive the LED.
// - Bidirectional port moves bytes both ways; unidirectional sends nibbles to host.
// - Range 0xFFF000 to 0xFFFFFF decodes as host interface access.
// - Falling host strobe pulses the request interrupt, only while idle with no word in progress.
// - Read at 0xFFF000 raises acknowledge, lowers error line, stalls with ready high.
// - Strobe rising edge during stalled read drives ready low, ending the read.
// - Four bytes per word, least significant first, assembled into 32 bits.
// - Write at 0xFFF000 raises acknowledge, lowers error line, stalls with ready high.
// - Strobe rising edge after host read drives ready low, ending the write.
// - Boot load skips the third and fourth bytes of the first word.
`timescale 1ns/1ps
`include "hpp_params.svh"
module hpp_decode
    import hpp_pkg::*;
#(
    parameter int IRQ_CYC = `HPP_IRQ_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic proc_strobe_b,
    input wire logic proc_rw,
    input wire logic [23:0] proc_addr,
    input wire logic [7:0] proc_wdata,
    output logic [7:0] proc_rdata,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic host_data_strobe,
    input wire logic host_bidir,
    input wire logic disconnect,
    input wire logic led_mode_a,
    output logic host_request_irq,
    output logic host_request_irq_oe,
    output logic proc_ready,
    output logic proc_ready_oe,
    output logic host_active_ack,
    output logic host_ack_indication,
    output logic host_error_b,
    output logic xcvr_en_b,
    output logic user_io_read_select,
    output logic user_io_write_select,
    output logic user_io_select,
    output logic user_ram_select,
    output logic user_boot_select,
    output logic led_in_a,
    output logic led_in_b,
    output logic [31:0] rx_word,
    output logic rx_word_valid
);
    // The pulse counter is eight bits wide
    if (IRQ_CYC < 1 || IRQ_CYC > 255)
    begin : g_irq_check
        $error("IRQ_CYC must be between 1 and 255 cycles");
    end

    function automatic logic hi_match(input logic [23:0] a, input logic [3:0] hi);
        hi_match = (a[23:20] == hi);
    endfunction : hi_match

    hpp_strobe_if sev ();
    hpp_strobe_sync u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .host_data_strobe(host_data_strobe),
        .ev(sev)
    );

    logic strb_meta_reg;
    logic strb_reg;
    logic rw_reg;
    logic bidir_meta_reg;
    logic bidir_reg;
    logic disc_meta_reg;
    logic disc_reg;
    logic led_mode_a_meta_reg;
    logic led_mode_a_reg;
    logic [7:0] hd_meta_reg;
    logic [7:0] hd_reg;
    logic [23:0] addr_reg;

    // Processor strobe and pins pass two flops, address and read/write one, before any decode
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strb_meta_reg <= 1'b1;
            strb_reg <= 1'b1;
            rw_reg <= 1'b1;
            addr_reg <= 24'h000000;
            bidir_meta_reg <= 1'b0;
            bidir_reg <= 1'b0;
            disc_meta_reg <= 1'b0;
            disc_reg <= 1'b0;
            led_mode_a_meta_reg <= 1'b0;
            led_mode_a_reg <= 1'b0;
            hd_meta_reg <= 8'h00;
            hd_reg <= 8'h00;
        end
        else
        begin
            strb_meta_reg <= proc_strobe_b;
            strb_reg <= strb_meta_reg;
            rw_reg <= proc_rw;
            addr_reg <= proc_addr;
            bidir_meta_reg <= host_bidir;
            bidir_reg <= bidir_meta_reg;
            disc_meta_reg <= disconnect;
            disc_reg <= disc_meta_reg;
            led_mode_a_meta_reg <= led_mode_a;
            led_mode_a_reg <= led_mode_a_meta_reg;
            hd_meta_reg <= host_data_in;
            hd_reg <= hd_meta_reg;
        end
    end

    logic bus_on;
    logic host_hit;
    logic data_hit;
    assign bus_on = ~strb_reg;
    assign host_hit = bus_on && ((addr_reg & `HPP_HOST_MASK) == `HPP_HOST_BASE);
    assign data_hit = host_hit && (addr_reg == `HPP_DATA_ADDR);

    hpp_state_t st_reg;
    hpp_state_t st_next;
    hpp_dir_t dir_reg;
    hpp_dir_t dir_next;
    logic busy_reg;
    logic busy_next;
    logic [7:0] irq_cnt_reg;
    logic [7:0] irq_cnt_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] hout_reg;
    logic [7:0] hout_next;
    logic step;
    logic boot_reg;
    logic boot_next;
    logic word_done;

    always_comb
    begin
        st_next = st_reg;
        dir_next = dir_reg;
        busy_next = busy_reg;
        irq_cnt_next = irq_cnt_reg;
        rdata_next = rdata_reg;
        hout_next = hout_reg;
        boot_next = boot_reg;
        step = 1'b0;
        if (irq_cnt_reg != 8'h00)
            irq_cnt_next = irq_cnt_reg - 8'h01;
        // Request interrupt only when no packet is moving
        if (sev.strobe_fall && !busy_reg && st_reg == HPP_IDLE)
            irq_cnt_next = 8'(IRQ_CYC);
        // Word end clears first, so a new access setting busy wins
        if (word_done)
        begin
            busy_next = 1'b0;
            boot_next = 1'b0;
        end
        case (st_reg)
            HPP_IDLE:
            begin
                if (data_hit)
                begin
                    st_next = HPP_STALL;
                    busy_next = 1'b1;
                    dir_next = rw_reg ? HPP_DIR_TO_CPU : HPP_DIR_TO_HOST;
                    // Unidirectional ports take the low nibble on the status lines
                    hout_next = bidir_reg ? proc_wdata : {4'h0, proc_wdata[3:0]};
                end
            end
            HPP_STALL:
            begin
                if (sev.strobe_rise)
                begin
                    st_next = HPP_RELEASE;
                    if (dir_reg == HPP_DIR_TO_CPU)
                    begin
                        rdata_next = hd_reg;
                        step = 1'b1;
                    end
                    else
                        busy_next = 1'b0;
                end
            end
            HPP_RELEASE:
            begin
                if (!bus_on)
                    st_next = HPP_IDLE;
            end
            default:
                st_next = HPP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= HPP_IDLE;
            dir_reg <= HPP_DIR_TO_CPU;
            busy_reg <= 1'b0;
            irq_cnt_reg <= 8'h00;
            rdata_reg <= 8'h00;
            hout_reg <= 8'h00;
            boot_reg <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
            dir_reg <= dir_next;
            busy_reg <= busy_next;
            irq_cnt_reg <= irq_cnt_next;
            rdata_reg <= rdata_next;
            hout_reg <= hout_next;
            boot_reg <= boot_next;
        end
    end

    hpp_word_pack #(.WORD_BYTES(`HPP_WORD_BYTES)) u_pack (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .step(step),
        .boot_mode(boot_reg),
        .rx_byte(hd_reg),
        .lane(),
        .word(rx_word),
        .word_done(word_done)
    );

    logic stalled;
    assign stalled = (st_reg == HPP_STALL);
    assign proc_rdata = rdata_reg;
    assign host_data_out = hout_reg;
    assign host_data_oe = stalled && (dir_reg == HPP_DIR_TO_HOST);
    assign rx_word_valid = word_done;
    assign host_active_ack = stalled;
    assign host_ack_indication = stalled;
    assign host_error_b = ~stalled;
    assign proc_ready = stalled;
    assign proc_ready_oe = ~disc_reg;
    assign host_request_irq = (irq_cnt_reg != 8'h00);
    assign host_request_irq_oe = ~disc_reg;
    assign xcvr_en_b = ~host_hit;
    assign user_io_select = bus_on && hi_match(addr_reg, `HPP_UIO_HI);
    assign user_io_read_select = user_io_select && rw_reg;
    assign user_io_write_select = user_io_select && !rw_reg;
    assign user_ram_select = bus_on && hi_match(addr_reg, `HPP_URAM_HI);
    assign user_boot_select = bus_on && hi_match(addr_reg, `HPP_UBOOT_HI);
    assign led_in_a = led_mode_a_reg & user_io_select;
    assign led_in_b = led_mode_a_reg & user_boot_select;

    sequence s_stall_start;
        (st_reg == HPP_IDLE) && data_hit;
    endsequence
    property p_stall;
        @(posedge sys_clk) disable iff (!rst_b)
        s_stall_start |=> (proc_ready && !host_error_b && host_active_ack);
    endproperty
    a_stall: assert property (p_stall) else $error("access to data address did not stall");
    property p_release;
        @(posedge sys_clk) disable iff (!rst_b)
        (stalled && sev.strobe_rise) |=> !proc_ready;
    endproperty
    a_release: assert property (p_release) else $error("ready not released on strobe rise");
    property p_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        (stalled && !sev.strobe_rise) |=> proc_ready;
    endproperty
    a_hold: assert property (p_hold) else $error("ready dropped without strobe rise");
    property p_irq;
        @(posedge sys_clk) disable iff (!rst_b)
        (sev.strobe_fall && !busy_reg && st_reg == HPP_IDLE) |=> host_request_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no interrupt on first strobe fall");
    property p_disc;
        @(posedge sys_clk) disable iff (!rst_b)
        (disconnect && $past(disconnect) && $past(disconnect, 2)) |-> (!proc_ready_oe && !host_request_irq_oe);
    endproperty
    a_disc: assert property (p_disc) else $error("outputs driven while disconnected");
    property p_xcvr;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_on && addr_reg[23:12] == 12'hFFF) |-> !xcvr_en_b;
    endproperty
    a_xcvr: assert property (p_xcvr) else $error("host window not decoded");
    property p_led;
        @(posedge sys_clk) disable iff (!rst_b)
        !led_mode_a_reg |-> (!led_in_a && !led_in_b);
    endproperty
    a_led: assert property (p_led) else $error("LED driven without led_mode_a mode");
    property p_nib;
        @(posedge sys_clk) disable iff (!rst_b)
        (s_stall_start and (!bidir_reg && !rw_reg)) |=> (hout_reg[7:4] == 4'h0);
    endproperty
    a_nib: assert property (p_nib) else $error("upper nibble sent on unidirectional port");
endmodule : hpp_decode

/* File: verilog/hpp_params.svh */
/*
 Timing counts, address fields and word size for the host parallel port decode logic.
 Assumes inclusion by bare name from files under verilog/.
*/
`ifndef HPP_PARAMS_SVH
`define HPP_PARAMS_SVH
`define HPP_ADDR_W 24
`define HPP_HOST_BASE 24'hFFF000
`define HPP_HOST_MASK 24'hFFF000
`define HPP_DATA_ADDR 24'hFFF000
`define HPP_UIO_HI 4'h8
`define HPP_URAM_HI 4'h4
`define HPP_UBOOT_HI 4'h0
`define HPP_TOP_HI 4'hF
`define HPP_IRQ_PULSE_NS 20
`define HPP_CLK_NS 5
`define HPP_IRQ_CYC ((`HPP_IRQ_PULSE_NS + `HPP_CLK_NS - 1) / `HPP_CLK_NS)
`define HPP_WORD_BYTES 4
`endif

/* File: verilog/hpp_pkg.sv */
/*
 Types shared by the host parallel port decode logic.
 Assumes hpp_params.svh is available for include.
*/
package hpp_pkg;
    typedef enum logic [1:0] {
        HPP_IDLE = 2'b00,
        HPP_STALL = 2'b01,
        HPP_RELEASE = 2'b10
    } hpp_state_t;
    typedef enum logic [0:0] {
        HPP_DIR_TO_CPU = 1'b0,
        HPP_DIR_TO_HOST = 1'b1
    } hpp_dir_t;
endpackage : hpp_pkg

/* File: verilog/hpp_strobe_if.sv */
/*
 Carries the synchronised host strobe events from the synchroniser to the handshake logic.
 Assumes one clock domain, sys_clk.
*/
`timescale 1ns/1ps
interface hpp_strobe_if;
    logic strobe_level;
    logic strobe_fall;
    logic strobe_rise;
    modport src (output strobe_level, output strobe_fall, output strobe_rise);
    modport dst (input strobe_level, input strobe_fall, input strobe_rise);
endinterface : hpp_strobe_if

/* File: verilog/hpp_strobe_sync.sv */
/*
 Two-stage synchroniser and edge detector for the asynchronous host data strobe.
 Assumes host_data_strobe comes from the host pin, asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module hpp_strobe_sync
    import hpp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic host_data_strobe,
    hpp_strobe_if.src ev
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    logic meta_next;
    logic sync_next;
    logic last_next;

    always_comb
    begin
        meta_next = host_data_strobe;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    // One pulse per edge, seen only after two stages
    assign ev.strobe_level = sync_reg;
    assign ev.strobe_fall = last_reg & ~sync_reg;
    assign ev.strobe_rise = ~last_reg & sync_reg;

    property p_one_rise;
        @(posedge sys_clk) disable iff (!rst_b)
        ev.strobe_rise |=> !ev.strobe_rise;
    endproperty
    a_one_rise: assert property (p_one_rise) else $error("strobe rise lasted more than one cycle");
endmodule : hpp_strobe_sync

/* File: verilog/hpp_word_pack.sv */
/*
 Byte lane sequencer: counts handshakes within a 32-bit word, least significant byte first,
 and assembles received bytes. Boot mode skips lanes 2 and 3 of the first word.
 Assumes step pulses come one per completed handshake from the same clock domain.
*/
`timescale 1ns/1ps
`include "hpp_params.svh"
module hpp_word_pack
    import hpp_pkg::*;
#(
    parameter int WORD_BYTES = `HPP_WORD_BYTES
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic step,
    input wire logic boot_mode,
    input wire logic [7:0] rx_byte,
    output logic [1:0] lane,
    output logic [31:0] word,
    output logic word_done
);
    if (WORD_BYTES != 4)
    begin : g_width_check
        $error("hpp_word_pack supports only four bytes per word");
    end

    logic [1:0] lane_reg;
    logic [1:0] lane_next;
    logic [31:0] word_reg;
    logic [31:0] word_next;
    logic done_reg;
    logic done_next;
    logic first_reg;
    logic first_next;

    always_comb
    begin
        lane_next = lane_reg;
        word_next = word_reg;
        done_next = 1'b0;
        first_next = first_reg;
        if (!boot_mode)
            first_next = 1'b1;
        if (step)
        begin
            word_next[lane_reg*8 +: 8] = rx_byte;
            // Boot stream acts as byte-wide memory: first word ends after two bytes
            if ((lane_reg == 2'd3) || (boot_mode && first_reg && lane_reg == 2'd1))
            begin
                lane_next = 2'd0;
                done_next = 1'b1;
                if (boot_mode)
                    first_next = 1'b0;
            end
            else
                lane_next = lane_reg + 2'd1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lane_reg <= 2'd0;
            word_reg <= 32'h00000000;
            done_reg <= 1'b0;
            first_reg <= 1'b1;
        end
        else
        begin
            lane_reg <= lane_next;
            word_reg <= word_next;
            done_reg <= done_next;
            first_reg <= first_next;
        end
    end

    assign lane = lane_reg;
    assign word = word_reg;
    assign word_done = done_reg;

    property p_lane_wrap;
        @(posedge sys_clk) disable iff (!rst_b)
        (step && lane_reg == 2'd3) |=> (lane_reg == 2'd0 && done_reg);
    endproperty
    a_lane_wrap: assert property (p_lane_wrap) else $error("lane did not wrap after fourth byte");
endmodule : hpp_word_pack

/* File: tb/hpp_host_model.sv */
/*
 Host printer port model: sends bytes with the data strobe and reads bytes or nibbles back.
 Assumes host_error_b and host_data_out come from the decode logic; drives on sys_clk edges.
*/
`timescale 1ns/1ps
module hpp_host_model
(
    input wire logic sys_clk,
    input wire logic host_error_b,
    input wire logic [7:0] host_data_out,
    output logic [7:0] host_data_in,
    output logic host_data_strobe,
    output logic [7:0] got_byte,
    output logic got_valid,
    output logic timed_out
);
    initial
    begin
        host_data_in = 8'h5A;
        host_data_strobe = 1'b1;
        got_byte = 8'h00;
        got_valid = 1'b0;
        timed_out = 1'b0;
    end

    task automatic wait_err(input logic lvl);
        int n;
        n = 0;
        while (host_error_b !== lvl && n < 200)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200)
            timed_out <= 1'b1;
    endtask : wait_err

    task automatic send_byte(input logic [7:0] b);
        @(posedge sys_clk);
        host_data_in <= b;
        repeat (2) @(posedge sys_clk);
        host_data_strobe <= 1'b0;
        wait_err(1'b0);
        @(posedge sys_clk);
        host_data_strobe <= 1'b1;
        wait_err(1'b1);
        // Released lines show the inverse so stale data cannot pass
        host_data_in <= ~b;
    endtask : send_byte

    task automatic recv_byte();
        wait_err(1'b0);
        @(posedge sys_clk);
        host_data_strobe <= 1'b0;
        repeat (2) @(posedge sys_clk);
        got_byte <= host_data_out;
        got_valid <= 1'b1;
        @(posedge sys_clk);
        got_valid <= 1'b0;
        host_data_strobe <= 1'b1;
        wait_err(1'b1);
    endtask : recv_byte
endmodule : hpp_host_model

/* File: tb/tb_top.sv */
/*
 Self-checking bench for the host parallel port decode logic.
 Assumes hpp_host_model stands in for the host printer port.
*/
`timescale 1ns/1ps
module tb_top;
    localparam int IRQ_LEN = 4;
    logic sys_clk, rst_b, proc_strobe_b, proc_rw, host_bidir, disconnect, led_mode_a;
    logic [23:0] proc_addr;
    logic [7:0] proc_wdata, proc_rdata, host_data_in, host_data_out, got_byte;
    logic host_data_oe, host_data_strobe, host_request_irq, host_request_irq_oe, proc_ready, proc_ready_oe;
    logic host_active_ack, host_ack_indication, host_error_b, xcvr_en_b, user_io_read_select;
    logic user_io_write_select, user_io_select, user_ram_select, user_boot_select, led_in_a, led_in_b;
    logic [31:0] rx_word;
    logic rx_word_valid, got_valid, timed_out, prev_ready;
    logic [63:0] m_w;
    logic [7:0] byte_q[$], tx_q[$];
    logic [63:0] word_q[$];
    int fails, comparisons, irqs, irq_len, seed;

    hpp_decode #(.IRQ_CYC(IRQ_LEN)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .proc_strobe_b(proc_strobe_b),
        .proc_rw(proc_rw), .proc_addr(proc_addr), .proc_wdata(proc_wdata), .proc_rdata(proc_rdata),
        .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .host_data_strobe(host_data_strobe), .host_bidir(host_bidir), .disconnect(disconnect),
        .led_mode_a(led_mode_a), .host_request_irq(host_request_irq), .host_request_irq_oe(host_request_irq_oe),
        .proc_ready(proc_ready), .proc_ready_oe(proc_ready_oe), .host_active_ack(host_active_ack),
        .host_ack_indication(host_ack_indication), .host_error_b(host_error_b), .xcvr_en_b(xcvr_en_b),
        .user_io_read_select(user_io_read_select), .user_io_write_select(user_io_write_select),
        .user_io_select(user_io_select), .user_ram_select(user_ram_select), .user_boot_select(user_boot_select),
        .led_in_a(led_in_a), .led_in_b(led_in_b), .rx_word(rx_word), .rx_word_valid(rx_word_valid));

    hpp_host_model i_host (.sys_clk(sys_clk), .host_error_b(host_error_b), .host_data_out(host_data_out),
        .host_data_in(host_data_in), .host_data_strobe(host_data_strobe), .got_byte(got_byte),
        .got_valid(got_valid), .timed_out(timed_out));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic results();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
            fails++;
        end
    endtask : check

    task automatic wait_ready(input logic lvl);
        int n;
        n = 0;
        while (proc_ready !== lvl && n < 100)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 100)
        begin
            fails++;
            results();
        end
    endtask : wait_ready

    task automatic proc_cycle(input logic rw, input logic [7:0] wd);
        @(posedge sys_clk);
        proc_strobe_b <= 1'b0;
        proc_rw <= rw;
        proc_addr <= 24'hFFF000;
        proc_wdata <= wd;
        wait_ready(1'b1);
        check(host_active_ack, 1, "ack");
        check(host_ack_indication, 1, "ack indication");
        check(host_error_b, 0, "error line");
        check(xcvr_en_b, 0, "transceiver");
        check(host_data_oe, !rw, "data drive");
        wait_ready(1'b0);
        @(posedge sys_clk);
        proc_strobe_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : proc_cycle

    task automatic read_byte(input logic [7:0] b);
        byte_q.push_back(b);
        fork
            i_host.send_byte(b);
            begin
                repeat (6) @(posedge sys_clk);
                proc_cycle(1'b1, 8'h00);
            end
        join
    endtask : read_byte

    task automatic write_byte(input logic [7:0] b, input logic bi);
        tx_q.push_back(bi ? b : {4'h0, b[3:0]});
        fork
            i_host.recv_byte();
            proc_cycle(1'b0, b);
        join
    endtask : write_byte

    task automatic sel_cycle(input int k);
        logic [23:0] a;
        logic led;
        a = {k[3:0], 20'h00000} | (24'($random(seed)) & 24'h0FFFFF);
        if (k == 15)
            a[19] = 1'b0;
        if (k == 16)
            a = 24'hFFF800 | (24'($random(seed)) & 24'h0007FF);
        led = k[1];
        @(posedge sys_clk);
        led_mode_a <= led;
        proc_strobe_b <= 1'b0;
        proc_rw <= k[0];
        proc_addr <= a;
        proc_wdata <= 8'($random(seed));
        repeat (5) @(posedge sys_clk);
        check(user_io_select, a[23:20] == 4'h8, "io select");
        check(user_ram_select, a[23:20] == 4'h4, "ram select");
        check(user_boot_select, a[23:20] == 4'h0, "boot select");
        check(user_io_read_select, a[23:20] == 4'h8 && k[0], "io read");
        check(user_io_write_select, a[23:20] == 4'h8 && !k[0], "io write");
        check(led_in_a, led && a[23:20] == 4'h8, "led a");
        check(led_in_b, led && a[23:20] == 4'h0, "led b");
        check(xcvr_en_b, a[23:12] != 12'hFFF, "window decode");
        check(proc_ready, 0, "stall off data address");
        @(posedge sys_clk);
        proc_strobe_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check({user_io_select, user_ram_select, user_boot_select}, 0, "selects idle");
    endtask : sel_cycle

    // Result watcher: takes the oldest note whenever an output shows a result
    always @(posedge sys_clk)
    begin
        if (timed_out === 1'b1)
        begin
            fails++;
            results();
        end
        if (rx_word_valid === 1'b1)
        begin
            if (word_q.size() == 0)
                check(32'h0, 32'h1, "unexpected word");
            else
            begin
                m_w = word_q.pop_front();
                check(rx_word & m_w[63:32], m_w[31:0] & m_w[63:32], "word");
            end
        end
        if (got_valid === 1'b1)
            check(got_byte, (tx_q.size() == 0) ? 32'h1FF : 32'(tx_q.pop_front()), "to host");
        if (proc_rw === 1'b1 && proc_strobe_b === 1'b0 && prev_ready === 1'b1 && proc_ready === 1'b0)
            check(proc_rdata, (byte_q.size() == 0) ? 32'h1FF : 32'(byte_q.pop_front()), "read byte");
        if (host_request_irq === 1'b1)
            irq_len++;
        else if (irq_len != 0)
        begin
            check(irq_len, IRQ_LEN, "irq pulse");
            irq_len = 0;
            irqs++;
        end
        prev_ready <= proc_ready;
    end

    initial
    begin
        logic [31:0] w;
        logic [7:0] b;
        fails = 0;
        comparisons = 0;
        irqs = 0;
        irq_len = 0;
        seed = 32'h6364FB40;
        prev_ready = 1'b0;
        rst_b = 1'b0;
        proc_strobe_b = 1'b1;
        proc_rw = 1'b1;
        proc_addr = 24'h000000;
        proc_wdata = 8'h00;
        host_bidir = 1'b1;
        disconnect = 1'b0;
        led_mode_a = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        disconnect <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check(host_request_irq_oe, 0, "irq enable");
        check(proc_ready_oe, 0, "ready enable");
        disconnect <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check(proc_ready_oe & host_request_irq_oe, 1, "drive enable");
        for (int k = 0; k < 17; k++)
            sel_cycle(k);
        for (int k = 0; k < 3; k++)
        begin
            w = $random(seed);
            word_q.push_back({(k == 0) ? 32'h0000FFFF : 32'hFFFFFFFF, w});
            for (int j = 0; j < ((k == 0) ? 2 : 4); j++)
                read_byte(w[8 * j +: 8]);
        end
        for (int k = 0; k < 12; k++)
        begin
            host_bidir <= (k < 4);
            b = $random(seed);
            write_byte(b, k < 4);
        end
        // A new packet request after a reply must interrupt again
        w = $random(seed);
        word_q.push_back({32'hFFFFFFFF, w});
        for (int j = 0; j < 4; j++)
            read_byte(w[8 * j +: 8]);
        repeat (4) @(posedge sys_clk);
        check(irqs, 4, "irq count");
        check(word_q.size() + tx_q.size() + byte_q.size(), 0, "pending results");
        results();
    end
endmodule : tb_top
